/* logic/pmc_defs.svh */
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets
`define PMC_OFF_CTRL 8'h00
`define PMC_OFF_IDLE_STOP 8'h04
`define PMC_OFF_STATUS 8'h08

// Control register field positions
`define PMC_CTRL_SLEEP_BIT 0
`define PMC_CTRL_DIV_LO 1
`define PMC_CTRL_DIV_HI 2
`define PMC_CTRL_SRC_LO 3
`define PMC_CTRL_SRC_HI 4
`define PMC_CTRL_POST_LO 5
`define PMC_CTRL_POST_HI 6
`define PMC_CTRL_RESET 7'h00

// Idle stop register reset value
`define PMC_IDLE_STOP_RESET 8'h00

// Status register field positions
`define PMC_STAT_MODE_LO 0
`define PMC_STAT_MODE_HI 3
`define PMC_STAT_OSC_BIT 4
`define PMC_STAT_TGT_BIT 5

// Peripheral count
`define PMC_NUM_PERIPH 8

// System clock rate and oscillator start-up times
`define PMC_CLK_MHZ 200
`define PMC_START_POSC_NS 1000
`define PMC_START_FRC_NS 100
`define PMC_START_SOSC_NS 2000
`define PMC_START_LOW_POWER_RC_OSCILLATOR_NS 500
// Least times, rounded up to whole cycles
`define PMC_NS_TO_CYC(ns) (((ns) * `PMC_CLK_MHZ + 999) / 1000)

`endif

/* logic/pmc_pkg.sv */
package pmc_pkg;

  // Power mode states, one-hot
  typedef enum logic [3:0] {
    PMC_RUN   = 4'b0001,
    PMC_IDLE  = 4'b0010,
    PMC_SLEEP = 4'b0100,
    PMC_WAKE  = 4'b1000
  } pmc_mode_e;

  // System clock source selection
  typedef enum logic [1:0] {
    PMC_SRC_FRC  = 2'b00,
    PMC_SRC_LOW_POWER_RC_OSCILLATOR = 2'b01,
    PMC_SRC_SOSC = 2'b10,
    PMC_SRC_POSC = 2'b11
  } pmc_src_e;

  // Start-up counter width
  typedef logic [11:0] pmc_cnt_t;

endpackage

/* logic/pmc_ctrl.sv */
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pmc_defs.svh"
// Notes on behaviour
// - Halted modes stop the core clock
// - Idle keeps system clock source running
// - Idle stops peripherals with stop bit set
// - Sleep halts core, source, clocked peripherals
// - Sleep keeps wake-capable functions alive
// - Clock monitor off during Sleep
// - Brown-out reset stays armed in Sleep
// - Sleep entry never clears watchdog counter
// - Higher-priority enabled interrupt wakes Sleep
// - Any reset ends Sleep
// - Low-priority wake restarts bus, enters Idle
// - Sleep exit waits source start-up delay
// - USB request keeps fast oscillators on
// - Pins keep their drive during Sleep
// - Core runs from selectable source, postscaled
// - Peripheral bus clock is divided system clock
// - Divider ratios 1:1, 1:2, 1:4, 1:8
// - Wait with sleep select clear enters Idle
// - Peripheral read completes on bus edge
module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core and interrupt logic
  input wire logic wait_exec,
  input wire logic irq_pending,
  input wire logic irq_in_sleep,
  input wire logic [2:0] irq_priority,
  input wire logic [2:0] cpu_priority,
  input wire logic wdt_timeout,
  input wire logic periph_rd_req,
  output logic periph_rd_done,
  // Oscillator side
  input wire logic osc_ready_pin,
  input wire logic usb_osc_hold,
  output logic system_clock_net_src_en,
  output logic [1:0] system_clock_net_sel,
  output logic [1:0] frc_postscale,
  // Clock gates and keep-alive enables
  output logic cpu_clk_en,
  output logic peripheral_bus_clock_tick,
  output logic [`PMC_NUM_PERIPH-1:0] periph_clk_en,
  output logic fail_safe_clock_monitor_en,
  output logic bor_en,
  output logic sleep_keep_en
);

  // Software registers
  logic [6:0] ctrl; // Sleep select, divider, source, postscale
  logic [`PMC_NUM_PERIPH-1:0] idle_stop_select; // Per-peripheral idle stop
  pmc_mode_e mode; // Power mode state
  pmc_mode_e next_mode;
  logic wake_to_idle; // Wake target after start-up
  logic next_wake_to_idle;
  pmc_cnt_t start_cnt; // Start-up delay counter
  pmc_cnt_t next_start_cnt;
  logic [2:0] pb_cnt; // Peripheral bus divider counter
  logic rd_pend; // Peripheral read waiting for bus edge
  logic osc_sync1; // Synchroniser first stage
  logic osc_ready; // Synchronised oscillator ready
  // AHB data-phase capture
  logic wr_pend;
  logic [7:0] wr_addr;

  // Control field decode
  wire sleep_select = ctrl[`PMC_CTRL_SLEEP_BIT];
  wire [1:0] peripheral_bus_divider = ctrl[`PMC_CTRL_DIV_HI:`PMC_CTRL_DIV_LO];
  wire [1:0] src_field = ctrl[`PMC_CTRL_SRC_HI:`PMC_CTRL_SRC_LO];
  wire [1:0] post_field = ctrl[`PMC_CTRL_POST_HI:`PMC_CTRL_POST_LO];

  // AHB decode
  wire bus_take = hsel && hready && htrans[1];
  wire rd_take = bus_take && !hwrite;
  wire hit_ctrl = (haddr == `PMC_OFF_CTRL);
  wire hit_stop = (haddr == `PMC_OFF_IDLE_STOP);
  wire hit_stat = (haddr == `PMC_OFF_STATUS);
  wire [31:0] stat_word = {26'h000_0000, wake_to_idle, osc_ready, mode};
  wire [31:0] rd_word = hit_ctrl ? {25'h000_0000, ctrl} :
                        hit_stop ? {24'h00_0000, idle_stop_select} :
                        hit_stat ? stat_word : 32'h0000_0000;
  wire wr_ctrl = wr_pend && (wr_addr == `PMC_OFF_CTRL);
  wire wr_stop = wr_pend && (wr_addr == `PMC_OFF_IDLE_STOP);

  // Mode decode
  wire in_run = (mode == PMC_RUN);
  wire in_idle = (mode == PMC_IDLE);
  wire in_sleep = (mode == PMC_SLEEP);
  wire in_wake = (mode == PMC_WAKE);
  // Interrupt qualification: strictly higher than core priority
  wire irq_high = irq_pending && (irq_priority > cpu_priority);
  wire irq_low = irq_pending && !(irq_priority > cpu_priority);
  // USB keeps fast oscillators alive in Sleep
  wire usb_keep = usb_osc_hold &&
                  ((src_field == PMC_SRC_POSC) || (src_field == PMC_SRC_FRC));

  // Start-up delay per selected source
  wire pmc_cnt_t start_load =
    (src_field == PMC_SRC_POSC) ? 12'(`PMC_NS_TO_CYC(`PMC_START_POSC_NS)) :
    (src_field == PMC_SRC_SOSC) ? 12'(`PMC_NS_TO_CYC(`PMC_START_SOSC_NS)) :
    (src_field == PMC_SRC_LOW_POWER_RC_OSCILLATOR) ? 12'(`PMC_NS_TO_CYC(`PMC_START_LOW_POWER_RC_OSCILLATOR_NS)) :
    12'(`PMC_NS_TO_CYC(`PMC_START_FRC_NS));

  // Peripheral bus divider terminal count
  wire [2:0] pb_mask = (3'h1 << peripheral_bus_divider) - 3'h1;
  wire pb_run = in_run || in_idle;
  wire pb_edge = pb_run && (pb_cnt == pb_mask);

  // Mode transitions
  always_comb begin
    next_mode = mode;
    next_wake_to_idle = wake_to_idle;
    next_start_cnt = start_cnt;
    unique case (mode)
      PMC_RUN: begin
        if (wait_exec) begin
          next_mode = sleep_select ? PMC_SLEEP : PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (irq_high || wdt_timeout) begin
          next_mode = PMC_RUN;
        end
      end
      PMC_SLEEP: begin
        if (wdt_timeout || (irq_high && irq_in_sleep)) begin
          next_mode = PMC_WAKE;
          next_wake_to_idle = 1'b0;
          next_start_cnt = usb_keep ? 12'h001 : start_load;
        end else if (irq_low && irq_in_sleep) begin
          next_mode = PMC_WAKE;
          next_wake_to_idle = 1'b1;
          next_start_cnt = usb_keep ? 12'h001 : start_load;
        end
      end
      PMC_WAKE: begin
        if (start_cnt > 12'h001) begin
          next_start_cnt = start_cnt - 12'h001;
        end else if (osc_ready || usb_keep) begin
          next_mode = wake_to_idle ? PMC_IDLE : PMC_RUN;
          next_start_cnt = 12'h000;
        end
      end
    endcase
  end

  // Mode register; reset of any kind lands in run mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= PMC_RUN;
      wake_to_idle <= 1'b0;
      start_cnt <= 12'h000;
    end else if (ce) begin
      mode <= next_mode;
      wake_to_idle <= next_wake_to_idle;
      start_cnt <= next_start_cnt;
    end
  end

  // Oscillator ready synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_sync1 <= 1'b0;
      osc_ready <= 1'b0;
    end else if (ce) begin
      osc_sync1 <= osc_ready_pin;
      osc_ready <= osc_sync1;
    end
  end

  // AHB address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend <= bus_take && hwrite;
      wr_addr <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_take) begin
        hrdata <= rd_word;
      end
    end
  end

  // Register writes in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PMC_CTRL_RESET;
      idle_stop_select <= `PMC_IDLE_STOP_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= hwdata[6:0];
      end
      if (wr_stop) begin
        idle_stop_select <= hwdata[`PMC_NUM_PERIPH-1:0];
      end
    end
  end

  // Peripheral bus divider and read completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_cnt <= 3'h0;
      peripheral_bus_clock_tick <= 1'b0;
      rd_pend <= 1'b0;
      periph_rd_done <= 1'b0;
    end else if (ce) begin
      pb_cnt <= pb_edge ? 3'h0 : (pb_run ? pb_cnt + 3'h1 : 3'h0);
      peripheral_bus_clock_tick <= pb_edge;
      rd_pend <= (rd_pend || periph_rd_req) && !pb_edge;
      periph_rd_done <= (rd_pend || periph_rd_req) && pb_edge;
    end
  end

  // Core and source gating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en <= 1'b1;
      system_clock_net_src_en <= 1'b1;
      system_clock_net_sel <= PMC_SRC_FRC;
      frc_postscale <= 2'b00;
      fail_safe_clock_monitor_en <= 1'b1;
      bor_en <= 1'b1;
      sleep_keep_en <= 1'b1;
    end else if (ce) begin
      cpu_clk_en <= (next_mode == PMC_RUN);
      system_clock_net_src_en <= !(next_mode == PMC_SLEEP) || usb_keep;
      system_clock_net_sel <= src_field;
      frc_postscale <= post_field;
      fail_safe_clock_monitor_en <= !((next_mode == PMC_SLEEP) || (next_mode == PMC_WAKE));
      bor_en <= 1'b1;
      // Pin-change, watchdog, ADC, UART, LOW_POWER_RC_OSCILLATOR and external-clock units
      // stay enabled; no watchdog clear and no pin override exist here
      sleep_keep_en <= 1'b1;
    end
  end

  // Per-peripheral clock gates
  genvar gi;
  generate
    for (gi = 0; gi < `PMC_NUM_PERIPH; gi = gi + 1) begin : g_gate
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          periph_clk_en[gi] <= 1'b1;
        end else if (ce) begin
          periph_clk_en[gi] <= ((next_mode == PMC_RUN) ||
            ((next_mode == PMC_IDLE) && !idle_stop_select[gi]));
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  core_halt_a: assert property (ce && !in_run |-> !cpu_clk_en)
    else $error("core clock runs in halted mode");
  src_idle_a: assert property (ce && in_idle |=> system_clock_net_src_en)
    else $error("source stopped in idle");
  idle_stop_a: assert property (ce && in_idle && idle_stop_select[0]
    && $stable(idle_stop_select) |-> !periph_clk_en[0])
    else $error("stopped peripheral still clocked in idle");
  sleep_halt_a: assert property (ce && in_sleep && !usb_keep && $stable(usb_keep)
    |-> !system_clock_net_src_en && !cpu_clk_en && periph_clk_en == '0)
    else $error("sleep left a clock running");
  fail_safe_clock_monitor_sleep_a: assert property (ce && in_sleep |=> !fail_safe_clock_monitor_en)
    else $error("clock monitor active in sleep");
  bor_live_a: assert property (!in_run |-> bor_en && sleep_keep_en)
    else $error("keep-alive dropped");
  wake_irq_a: assert property (ce && in_sleep && irq_high && irq_in_sleep
    |=> in_wake && !wake_to_idle)
    else $error("higher priority interrupt did not wake");
  wdt_wake_a: assert property (ce && in_idle && wdt_timeout |=> in_run)
    else $error("watchdog did not end idle");
  low_prio_a: assert property (ce && in_sleep && !wdt_timeout && irq_low && irq_in_sleep
    |=> in_wake && wake_to_idle)
    else $error("low priority wake not routed to idle");
  wait_mode_a: assert property (ce && in_run && wait_exec
    |=> (mode == ($past(sleep_select) ? PMC_SLEEP : PMC_IDLE)))
    else $error("wait entered wrong mode");
  pb_ratio_a: assert property ((ce && pb_run && pb_cnt == 3'h0
    && peripheral_bus_divider == 2'b11) ##1 (ce && pb_run && $stable(ctrl))[*7] |-> pb_edge)
    else $error("divide by eight edge missed");
  rd_done_a: assert property (periph_rd_done |-> peripheral_bus_clock_tick)
    else $error("read completed off bus edge");

  sleep_wake_c: cover property (in_sleep ##1 in_wake ##[1:600] in_run);
  sleep_idle_c: cover property (in_sleep ##1 in_wake && wake_to_idle ##[1:600] in_idle);
  idle_run_c: cover property (in_idle ##1 in_run);
  pb_read_c: cover property (periph_rd_req ##[1:8] periph_rd_done);

endmodule // pmc_ctrl

/* test/pmc_osc_model.sv */
`timescale 1ns/1ps
module pmc_osc_model #(
  parameter int START_CYC = 8 // Settling time of the modelled oscillator
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Source enable from the controller
  input wire logic system_clock_net_src_en,
  // Stable indication back to the controller
  output logic osc_ready_pin
);
  logic [7:0] settle_cnt; // Cycles run since the source was enabled

  // Ready only after the settling time; a stopped source is never ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= 8'h00;
      osc_ready_pin <= 1'b0;
    end else if (!system_clock_net_src_en) begin
      settle_cnt <= 8'h00;
      osc_ready_pin <= 1'b0;
    end else if (settle_cnt < 8'(START_CYC)) begin
      settle_cnt <= settle_cnt + 8'h01;
      osc_ready_pin <= 1'b0;
    end else begin
      osc_ready_pin <= 1'b1;
    end
  end
endmodule // pmc_osc_model

/* test/tb.sv */
`timescale 1ns/1ps
`include "pmc_defs.svh"
module tb
  import pmc_pkg::*;
;
  localparam int frc_cyc = `PMC_START_FRC_NS * `PMC_CLK_MHZ / 1000; // Fast RC start-up
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wait_exec = 1'b0;
  logic irq_pending = 1'b0, irq_in_sleep = 1'b0, wdt_timeout = 1'b0;
  logic periph_rd_req = 1'b0, usb_osc_hold = 1'b0, ce = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic [2:0] irq_priority = 3'h0, cpu_priority = 3'h3;
  logic hreadyout, hresp, periph_rd_done, system_clock_net_src_en, cpu_clk_en, peripheral_bus_clock_tick;
  logic fail_safe_clock_monitor_en, bor_en, sleep_keep_en, osc_ready_pin;
  logic [1:0] system_clock_net_sel, frc_postscale;
  logic [7:0] periph_clk_en;
  int n_fail = 0, n_compared = 0, i, k;

  // Device under test, bus ready looped back
  pmc_ctrl dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .wait_exec,
    .irq_pending, .irq_in_sleep, .irq_priority, .cpu_priority, .wdt_timeout,
    .periph_rd_req, .periph_rd_done, .osc_ready_pin, .usb_osc_hold, .system_clock_net_src_en,
    .system_clock_net_sel, .frc_postscale, .cpu_clk_en, .peripheral_bus_clock_tick, .periph_clk_en, .fail_safe_clock_monitor_en,
    .bor_en, .sleep_keep_en);

  // Oscillator at the far side
  pmc_osc_model osc_u (.hclk, .hresetn, .system_clock_net_src_en, .osc_ready_pin);

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  // Bounded wait for a level, cycles in k
  task automatic until_hi(ref logic s);
    k = 0;
    while (s !== 1'b1 && k < 1000) begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask

  // Select the halted mode and execute a wait
  task automatic halt(input logic slp);
    bus(1'b1, `PMC_OFF_CTRL, {31'h0000_0000, slp});
    @(posedge hclk);
    wait_exec <= 1'b1;
    @(posedge hclk);
    wait_exec <= 1'b0;
    #1;
  endtask

  // One-cycle watchdog time-out pulse
  task automatic wdt_pulse;
    @(posedge hclk);
    wdt_timeout <= 1'b1;
    @(posedge hclk);
    wdt_timeout <= 1'b0;
    #1;
  endtask

  // Counts and verdict
  task automatic wrap_up;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    #50000;
    n_fail++;
    wrap_up;
  end

  // Test sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk({cpu_clk_en, fail_safe_clock_monitor_en, bor_en, sleep_keep_en, periph_clk_en}, 32'h0000_0FFF);
    bus(1'b0, `PMC_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'(PMC_RUN));
    bus(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, `PMC_OFF_IDLE_STOP, 32'h0000_000F);
    bus(1'b0, `PMC_OFF_IDLE_STOP, 32'h0000_0000);
    chk(rd, 32'h0000_000F);
    // Every source with a distinct postscale
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `PMC_OFF_CTRL, 32'(((3 - i) << 5) | (i << 3)));
      @(posedge hclk);
      #1;
      chk({system_clock_net_sel, frc_postscale}, 32'((i << 2) | (3 - i)));
    end
    // Every divider: tick spacing and read latency
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `PMC_OFF_CTRL, 32'(i << 1));
      until_hi(peripheral_bus_clock_tick);
      @(posedge hclk);
      #1;
      until_hi(peripheral_bus_clock_tick);
      chk(32'(k + 1), 32'(1 << i));
      @(posedge hclk);
      periph_rd_req <= 1'b1;
      @(posedge hclk);
      periph_rd_req <= 1'b0;
      #1;
      until_hi(periph_rd_done);
      chk(32'(k < (2 << i)), 32'h0000_0001);
    end
    // Idle keeps the source, stops selected peripherals
    halt(1'b0);
    chk({cpu_clk_en, system_clock_net_src_en, periph_clk_en}, 32'h0000_01F0);
    bus(1'b0, `PMC_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'(PMC_IDLE));
    // Clock enable low freezes the mode against a time-out
    ce <= 1'b0;
    wdt_pulse;
    chk(cpu_clk_en, 1'b0);
    ce <= 1'b1;
    wdt_pulse;
    chk(cpu_clk_en, 1'b1);
    // Sleep gates everything but keep-alive units
    halt(1'b1);
    chk({cpu_clk_en, system_clock_net_src_en, fail_safe_clock_monitor_en, bor_en, sleep_keep_en}, 32'h0000_0003);
    chk(periph_clk_en, 32'h0000_0000);
    @(posedge hclk);
    irq_pending <= 1'b1;
    irq_priority <= 3'h4;
    repeat (3) @(posedge hclk);
    #1;
    chk(cpu_clk_en, 1'b0);
    @(posedge hclk);
    irq_in_sleep <= 1'b1;
    until_hi(cpu_clk_en);
    chk(32'(k >= frc_cyc && k < 1000), 32'h0000_0001);
    // Equal priority wakes into Idle
    irq_pending <= 1'b0;
    halt(1'b1);
    irq_pending <= 1'b1;
    irq_priority <= 3'h3;
    until_hi(fail_safe_clock_monitor_en);
    chk({cpu_clk_en, periph_clk_en}, 32'h0000_00F0);
    bus(1'b0, `PMC_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'(PMC_IDLE));
    irq_pending <= 1'b0;
    wdt_pulse;
    // USB hold keeps the source; watchdog wakes Sleep
    usb_osc_hold <= 1'b1;
    halt(1'b1);
    chk(system_clock_net_src_en, 1'b1);
    wdt_pulse;
    until_hi(cpu_clk_en);
    chk(cpu_clk_en, 1'b1);
    usb_osc_hold <= 1'b0;
    // Reset ends Sleep
    halt(1'b1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk(cpu_clk_en, 1'b1);
    bus(1'b0, `PMC_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'(PMC_RUN));
    wrap_up;
  end
endmodule // tb
